// >>> design/smwr_pkg.sv
// package: register map, field layout, reset values and timing of the stop release block
package smwr_pkg;

  // ************************************************
  // bus geometry
  // ************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [3:0] SYS_CONTROL_ONE_OFS = 4'h0;
  localparam logic [3:0] WARMUP_COUNT_CONTROL_OFS = 4'h1;
  localparam logic [3:0] WARMUP_LENGTH_OFS = 4'h2;
  localparam logic [3:0] KEY_WAKE_CONTROL_OFS = 4'h3;
  localparam logic [3:0] WAKE_STATUS_OFS = 4'h4;

  // ************************************************
  // field positions
  // ************************************************
  localparam int STOP_REQ_BIT = 7;
  localparam int RELEASE_SEL_BIT = 6;
  localparam int CLK_SEL_LSB = 0;
  localparam int CLK_SEL_W = 2;
  localparam int KEY_LEVEL_BIT = 0;
  localparam int KEY_ENABLE_BIT = 1;
  localparam int ST_PORT_BIT = 0;
  localparam int ST_KEY_BIT = 1;
  localparam int ST_STOPPED_BIT = 2;
  localparam int ST_WARMING_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_SRC_LSB = 5;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [7:0] WARMUP_COUNT_CONTROL_RST = 8'h00;
  localparam logic [7:0] WARMUP_LENGTH_RST = 8'h10;
  localparam logic [7:0] KEY_WAKE_CONTROL_RST = 8'h00;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MACHINE_CYCLE_NS = 40;
  localparam int MACHINE_CYCLE_CLKS = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SMWR_RUN, SMWR_ARMING, SMWR_STOPPED, SMWR_WARMUP} smwr_state_t;

endpackage : smwr_pkg

// >>> design/smwr_stop_release.sv
// top: registers, stop entry and release sequencing, warm-up and resume
`timescale 1ns/10ps
module smwr_stop_release
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic wakePin,
  input wire logic keyPin,
  input wire logic [1:0] mainClkSrc,
  output logic oscRun,
  output logic cpuHalt,
  output logic warmupActive,
  output logic [1:0] warmupSrc,
  output logic timingClear,
  output logic resumePulse,
  output logic sharedPortBit,
  output logic extInterruptFive
);

  // ************************************************
  // declarations
  // ************************************************
  smwr_pkg::smwr_state_t state_reg;
  smwr_pkg::smwr_state_t state_next;
  logic wakeReleaseSelect_reg;
  logic [1:0] warmupClockSelect_reg;
  logic [7:0] warmupLength_reg;
  logic keyLevel_reg;
  logic keyEnable_reg;
  logic [1:0] entrySrc_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic stopping_reg;
  logic armed_reg;
  logic refused_reg;
  logic pinLast_reg;
  logic [2:0] syncVec;
  logic pinSync;
  logic keySync;
  logic wakeSync;
  logic stopWrite;
  logic entryRefused;

  smwr_wake_if wif ();

  // ************************************************
  // pin synchronisation and wake latch
  // ************************************************
  smwr_sync #(.W(3)) uSync
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .asyncIn({wif.wakeAsync, keyPin, wakePin}),
    .syncOut(syncVec)
  );

  assign pinSync = syncVec[0];
  assign keySync = syncVec[1];
  assign wakeSync = syncVec[2];

  assign wif.wakePin = wakePin;
  assign wif.keyPin = keyPin;
  assign wif.levelMode = wakeReleaseSelect_reg;
  assign wif.keyLevel = keyLevel_reg;
  assign wif.keyEnable = keyEnable_reg;
  assign wif.stopping = stopping_reg;
  assign wif.armed = armed_reg;

  smwr_wake_latch uLatch
  (
    .w(wif.latch)
  );

  // ************************************************
  // register decode helpers
  // ************************************************
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // a write to the control register with the stop bit set requests entry
  assign stopWrite = regWrStb
                   && hit(regAddr, smwr_pkg::SYS_CONTROL_ONE_OFS)
                   && regWrData[smwr_pkg::STOP_REQ_BIT];

  // the mode in force is the one written together with the stop bit,
  // so 0x80 alone means edge release with the pin in any state
  assign entryRefused = regWrData[smwr_pkg::RELEASE_SEL_BIT] && pinSync;

  // ************************************************
  // software registers
  // ************************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wakeReleaseSelect_reg <= 1'b0;
    else if (regWrStb && hit(regAddr, smwr_pkg::SYS_CONTROL_ONE_OFS) && state_reg == smwr_pkg::SMWR_RUN)
      wakeReleaseSelect_reg <= regWrData[smwr_pkg::RELEASE_SEL_BIT];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      warmupClockSelect_reg <= smwr_pkg::WARMUP_COUNT_CONTROL_RST[1:0];
    else if (regWrStb && hit(regAddr, smwr_pkg::WARMUP_COUNT_CONTROL_OFS))
      warmupClockSelect_reg <= regWrData[smwr_pkg::CLK_SEL_LSB +: smwr_pkg::CLK_SEL_W];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      warmupLength_reg <= smwr_pkg::WARMUP_LENGTH_RST;
    else if (regWrStb && hit(regAddr, smwr_pkg::WARMUP_LENGTH_OFS))
      warmupLength_reg <= regWrData;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      keyLevel_reg <= smwr_pkg::KEY_WAKE_CONTROL_RST[smwr_pkg::KEY_LEVEL_BIT];
      keyEnable_reg <= smwr_pkg::KEY_WAKE_CONTROL_RST[smwr_pkg::KEY_ENABLE_BIT];
    end
    else if (regWrStb && hit(regAddr, smwr_pkg::KEY_WAKE_CONTROL_OFS))
    begin
      keyLevel_reg <= regWrData[smwr_pkg::KEY_LEVEL_BIT];
      keyEnable_reg <= regWrData[smwr_pkg::KEY_ENABLE_BIT];
    end
  end

  // ************************************************
  // read port
  // ************************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= 8'h00;
    else if (regRdStb)
    begin
      regRdData <= 8'h00;
      unique case (regAddr)
        smwr_pkg::SYS_CONTROL_ONE_OFS:
        begin
          regRdData[smwr_pkg::STOP_REQ_BIT] <= (state_reg != smwr_pkg::SMWR_RUN);
          regRdData[smwr_pkg::RELEASE_SEL_BIT] <= wakeReleaseSelect_reg;
        end
        smwr_pkg::WARMUP_COUNT_CONTROL_OFS:
          regRdData[smwr_pkg::CLK_SEL_LSB +: smwr_pkg::CLK_SEL_W] <= warmupClockSelect_reg;
        smwr_pkg::WARMUP_LENGTH_OFS:
          regRdData <= warmupLength_reg;
        smwr_pkg::KEY_WAKE_CONTROL_OFS:
        begin
          regRdData[smwr_pkg::KEY_LEVEL_BIT] <= keyLevel_reg;
          regRdData[smwr_pkg::KEY_ENABLE_BIT] <= keyEnable_reg;
        end
        smwr_pkg::WAKE_STATUS_OFS:
        begin
          regRdData[smwr_pkg::ST_PORT_BIT] <= pinSync;
          regRdData[smwr_pkg::ST_KEY_BIT] <= keySync;
          regRdData[smwr_pkg::ST_STOPPED_BIT] <= stopping_reg;
          regRdData[smwr_pkg::ST_WARMING_BIT] <= (state_reg == smwr_pkg::SMWR_WARMUP);
          regRdData[smwr_pkg::ST_REFUSED_BIT] <= refused_reg;
          regRdData[smwr_pkg::ST_SRC_LSB +: 2] <= entrySrc_reg;
        end
        default:
          regRdData <= 8'h00;
      endcase
    end
  end

  // ************************************************
  // sequencer
  // ************************************************
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      smwr_pkg::SMWR_RUN:
      begin
        if (stopWrite && !entryRefused)
        begin
          state_next = smwr_pkg::SMWR_ARMING;
          cnt_next = 8'(smwr_pkg::MACHINE_CYCLE_CLKS - 1);
        end
      end
      smwr_pkg::SMWR_ARMING:
      begin
        // edges are not yet latched here; only levels can release
        if (wakeSync)
        begin
          state_next = smwr_pkg::SMWR_WARMUP;
          cnt_next = warmupLength_reg;
        end
        else if (cnt_reg == 8'h00)
          state_next = smwr_pkg::SMWR_STOPPED;
        else
          cnt_next = cnt_reg - 8'h01;
      end
      smwr_pkg::SMWR_STOPPED:
      begin
        if (wakeSync)
        begin
          state_next = smwr_pkg::SMWR_WARMUP;
          cnt_next = warmupLength_reg;
        end
      end
      smwr_pkg::SMWR_WARMUP:
      begin
        // wake inputs are not looked at, so no pin or key change restops
        if (cnt_reg == 8'h00)
          state_next = smwr_pkg::SMWR_RUN;
        else
          cnt_next = cnt_reg - 8'h01;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= smwr_pkg::SMWR_RUN;
      cnt_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ************************************************
  // levels handed to the clockless latch
  // ************************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stopping_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      stopping_reg <= (state_next == smwr_pkg::SMWR_ARMING) || (state_next == smwr_pkg::SMWR_STOPPED);
      armed_reg <= (state_next == smwr_pkg::SMWR_STOPPED) && !wakeReleaseSelect_reg;
    end
  end

  // ************************************************
  // entry capture and refusal status
  // ************************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      entrySrc_reg <= 2'h0;
    else if (state_reg == smwr_pkg::SMWR_RUN && state_next == smwr_pkg::SMWR_ARMING)
      entrySrc_reg <= mainClkSrc;
  end

  // set by a refused entry, cleared by the next accepted one
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      refused_reg <= 1'b0;
    else if (stopWrite && state_reg == smwr_pkg::SMWR_RUN)
      refused_reg <= entryRefused;
  end

  // ************************************************
  // outputs
  // ************************************************
  // a wake must restart the oscillator without any clock edge
  assign oscRun = !stopping_reg || wif.wakeAsync;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpuHalt <= 1'b0;
      warmupActive <= 1'b0;
      warmupSrc <= 2'h0;
    end
    else
    begin
      cpuHalt <= (state_next != smwr_pkg::SMWR_RUN);
      warmupActive <= (state_next == smwr_pkg::SMWR_WARMUP);
      // the selection field is overridden only while a stop release warms up
      if (state_next == smwr_pkg::SMWR_WARMUP)
        warmupSrc <= entrySrc_reg;
      else
        warmupSrc <= warmupClockSelect_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timingClear <= 1'b0;
      resumePulse <= 1'b0;
    end
    else
    begin
      timingClear <= (state_reg == smwr_pkg::SMWR_WARMUP) && (state_next == smwr_pkg::SMWR_RUN);
      resumePulse <= (state_reg == smwr_pkg::SMWR_WARMUP) && (state_next == smwr_pkg::SMWR_RUN);
    end
  end

  // the shared pin as a port bit and as interrupt five on its rising edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinLast_reg <= 1'b0;
      sharedPortBit <= 1'b0;
      extInterruptFive <= 1'b0;
    end
    else
    begin
      pinLast_reg <= pinSync;
      sharedPortBit <= pinSync;
      extInterruptFive <= pinSync && !pinLast_reg;
    end
  end

endmodule : smwr_stop_release

// >>> design/smwr_sync.sv
// module: two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module smwr_sync
#(
  parameter int W = 3
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule : smwr_sync

// >>> design/smwr_wake_if.sv
// interface: signals between the sequencer and the clockless wake latch
`timescale 1ns/10ps
interface smwr_wake_if;
  logic wakePin;
  logic keyPin;
  logic levelMode;
  logic keyLevel;
  logic keyEnable;
  logic stopping;
  logic armed;
  logic edgeHeld;
  logic wakeAsync;

  modport ctrl
  (
    output wakePin, keyPin, levelMode, keyLevel, keyEnable, stopping, armed,
    input edgeHeld, wakeAsync
  );

  modport latch
  (
    input wakePin, keyPin, levelMode, keyLevel, keyEnable, stopping, armed,
    output edgeHeld, wakeAsync
  );
endinterface : smwr_wake_if

// >>> design/smwr_wake_latch.sv
// module: wake detection that works while every clock is stopped
`timescale 1ns/10ps
module smwr_wake_latch
(
  smwr_wake_if.latch w
);
  logic edgeHeld;

  // clocked by the pin itself, so an edge is caught with the oscillators off
  always_ff @(posedge w.wakePin or negedge w.armed)
  begin
    if (!w.armed)
      edgeHeld <= 1'b0;
    else
      edgeHeld <= 1'b1;
  end

  assign w.edgeHeld = edgeHeld;

  // pure gates: this path restarts the oscillator before any clock exists
  assign w.wakeAsync = (w.stopping & w.levelMode & w.wakePin)
                     | (~w.levelMode & edgeHeld)
                     | (w.stopping & w.keyEnable & (w.keyPin == w.keyLevel));
endmodule : smwr_wake_latch

// >>> test/smwr_stop_release_monitor.sv
// checker: port-level assertions for the stop release block
`timescale 1ns/10ps
module smwr_stop_release_monitor
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  input wire logic wakePin,
  input wire logic keyPin,
  input wire logic [1:0] mainClkSrc,
  input wire logic oscRun,
  input wire logic cpuHalt,
  input wire logic warmupActive,
  input wire logic [1:0] warmupSrc,
  input wire logic timingClear,
  input wire logic resumePulse,
  input wire logic sharedPortBit,
  input wire logic extInterruptFive
);
  // ************************************************
  // helper state
  // ************************************************
  logic [7:0] haltCnt;
  logic armWait;
  logic [7:0] lastCtl;
  logic [1:0] keyCtl;
  logic [1:0] entrySrc;
  logic ctlWr;
  // cpuHalt low means the sequencer is back in run, so the write is taken
  assign ctlWr = regWrStb && regAddr == 4'h0 && !cpuHalt;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      haltCnt <= 8'h00;
      armWait <= 1'b0;
      lastCtl <= 8'h00;
      keyCtl <= 2'h0;
      entrySrc <= 2'h0;
    end
    else
    begin
      haltCnt <= !cpuHalt ? 8'h00 : (haltCnt == 8'hFF ? haltCnt : haltCnt + 8'h01);
      // waiting for a wake: from the first halted cycle until warm-up starts
      armWait <= cpuHalt && !warmupActive && (armWait || haltCnt == 8'h00);
      if (ctlWr)
      begin
        lastCtl <= regWrData;
        entrySrc <= mainClkSrc;
      end
      if (regWrStb && regAddr == 4'h3)
        keyCtl <= regWrData[1:0];
    end
  // ************************************************
  // properties
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence pinHeld;
    wakePin [*4];
  endsequence
  sequence lateRise;
    armWait && haltCnt > 8'h05 && $rose(wakePin);
  endsequence
  sequence earlyRise;
    armWait && haltCnt < 8'h04 && !lastCtl[6] && !keyCtl[1] && $rose(wakePin);
  endsequence
  stop_entry_a: assert property (ctlWr && regWrData == 8'h80 |=> cpuHalt && !oscRun)
    else $error("stop write did not halt");
  level_refuse_a: assert property (pinHeld ##0 (ctlWr && regWrData == 8'hC0) |=> !cpuHalt)
    else $error("level stop entered with pin high");
  run_osc_a: assert property (!cpuHalt |-> oscRun)
    else $error("oscillator off while running");
  warm_source_a: assert property (warmupActive |-> warmupSrc == entrySrc)
    else $error("warm-up source differs from entry clock");
  resume_pair_a: assert property (timingClear |-> resumePulse ##1 !(timingClear || resumePulse))
    else $error("resume pulses misaligned");
  warm_bound_a: assert property ($rose(warmupActive) |-> ##[1:300] timingClear)
    else $error("warm-up never ended");
  edge_release_a: assert property (lateRise |-> ##[1:5] warmupActive)
    else $error("rising wake edge did not release");
  edge_ignore_a: assert property (earlyRise ##1 wakePin [*8] |-> !warmupActive)
    else $error("early edge released stop");
  level_release_a: assert property (armWait && lastCtl[6] && wakePin && !warmupActive |-> ##[1:5] warmupActive)
    else $error("high pin did not release");
  key_release_a: assert property (armWait && haltCnt > 8'h05 && keyCtl[1] && keyPin == keyCtl[0]
    && !warmupActive |-> ##[1:5] warmupActive) else $error("key level did not release");
  port_irq_a: assert property (!cpuHalt && $rose(wakePin) |-> ##[1:5] extInterruptFive)
    else $error("pin edge raised no interrupt");
endmodule : smwr_stop_release_monitor

bind smwr_stop_release smwr_stop_release_monitor u_monitor
(
  .sys_clk, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .wakePin, .keyPin,
  .mainClkSrc, .oscRun, .cpuHalt, .warmupActive, .warmupSrc, .timingClear, .resumePulse,
  .sharedPortBit, .extInterruptFive
);

// >>> test/smwr_wake_source.sv
// partner: wake pin and key input source, answering after a chosen delay
`timescale 1ns/10ps
module smwr_wake_source
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic srcLoad,
  input wire logic [7:0] srcDly,
  input wire logic nextWake,
  input wire logic nextKey,
  output logic wakePin,
  output logic keyPin
);
  logic [7:0] dlyCnt_reg;
  logic pend_reg;
  logic wake_reg;
  logic key_reg;
  // a nonzero delay models a slow source, zero a prompt one
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      dlyCnt_reg <= 8'h00;
      pend_reg <= 1'b0;
      wake_reg <= 1'b0;
      key_reg <= 1'b0;
      wakePin <= 1'b0;
      keyPin <= 1'b0;
    end
    else if (srcLoad)
    begin
      dlyCnt_reg <= srcDly;
      pend_reg <= 1'b1;
      wake_reg <= nextWake;
      key_reg <= nextKey;
    end
    else if (pend_reg && dlyCnt_reg == 8'h00)
    begin
      wakePin <= wake_reg;
      keyPin <= key_reg;
      pend_reg <= 1'b0;
    end
    else if (pend_reg)
      dlyCnt_reg <= dlyCnt_reg - 8'h01;
endmodule : smwr_wake_source

// >>> test/tb_smwr_stop_release.sv
// testbench: scenario tasks for the stop release block
`timescale 1ns/10ps
module tb_smwr_stop_release;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [1:0] mainClkSrc = 2'h2;
  logic srcLoad = 1'b0;
  logic [7:0] srcDly = 8'h00;
  logic nextWake = 1'b0;
  logic nextKey = 1'b0;
  logic [7:0] regRdData;
  logic wakePin, keyPin, oscRun, cpuHalt, warmupActive, timingClear, resumePulse, sharedPortBit, extInterruptFive;
  logic [1:0] warmupSrc;
  logic [7:0] rdv;
  logic [1:0] firstSrc;
  int warmCnt;
  int mismatches = 0;
  int n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  smwr_stop_release u_dut (.sys_clk, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .wakePin,
    .keyPin, .mainClkSrc, .oscRun, .cpuHalt, .warmupActive, .warmupSrc, .timingClear, .resumePulse,
    .sharedPortBit, .extInterruptFive);
  smwr_wake_source u_source (.sys_clk, .rst_b, .srcLoad, .srcDly, .nextWake, .nextKey, .wakePin, .keyPin);
  // ************************************************
  // shared tasks
  // ************************************************
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 rdv = regRdData;
  endtask : rd
  task drive(input logic w, input logic k, input logic [7:0] d);
    @(posedge sys_clk);
    nextWake <= w;
    nextKey <= k;
    srcDly <= d;
    srcLoad <= 1'b1;
    @(posedge sys_clk);
    srcLoad <= 1'b0;
    #1;
  endtask : drive
  task waitRes;
    int i;
    logic got;
    got = 1'b0;
    warmCnt = 0;
    for (i = 0; i < 400 && !got; i++)
    begin
      idle(1);
      if (warmupActive === 1'b1)
      begin
        if (warmCnt == 0)
          firstSrc = warmupSrc;
        warmCnt++;
      end
      got = (resumePulse === 1'b1);
    end
    if (!got)
    begin
      mismatches++;
      finish_test();
    end
  endtask : waitRes
  // ************************************************
  // scenarios
  // ************************************************
  task t_regs;
    rd(4'h1);
    check(rdv, 8'h00);
    rd(4'h2);
    check(rdv, 8'h10);
    rd(4'h3);
    check(rdv, 8'h00);
    rd(4'hF);
    check(rdv, 8'h00);
    wr(4'h0, 8'h40);
    rd(4'h0);
    check(rdv, 8'h40);
    check({7'h00, cpuHalt}, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h05);
    wr(4'h1, 8'h01);
    rd(4'h2);
    check(rdv, 8'h05);
    $display("registers done");
  endtask : t_regs
  task t_edge;
    drive(1'b1, 1'b0, 8'h00);
    idle(3);
    wr(4'h0, 8'h80);
    check({cpuHalt, oscRun}, 8'h02);
    idle(10);
    rd(4'h4);
    check({6'h00, rdv[2], warmupActive}, 8'h02);
    check({6'h00, rdv[6:5]}, 8'h02);
    @(posedge sys_clk);
    mainClkSrc <= 2'h3;
    drive(1'b0, 1'b0, 8'h00);
    idle(3);
    drive(1'b1, 1'b0, 8'h14);
    waitRes();
    check({6'h00, firstSrc}, 8'h02);
    check(8'(warmCnt), 8'h06);
    check({7'h00, timingClear}, 8'h01);
    idle(1);
    check({7'h00, cpuHalt}, 8'h00);
    check({6'h00, warmupSrc}, 8'h01);
    $display("edge release done");
  endtask : t_edge
  task t_ignore;
    drive(1'b0, 1'b0, 8'h00);
    idle(3);
    wr(4'h0, 8'h80);
    drive(1'b1, 1'b0, 8'h00);
    idle(12);
    check({cpuHalt, warmupActive}, 8'h02);
    drive(1'b0, 1'b0, 8'h00);
    idle(3);
    drive(1'b1, 1'b0, 8'h00);
    waitRes();
    check({7'h00, timingClear}, 8'h01);
    $display("early edge done");
  endtask : t_ignore
  task t_level;
    idle(5);
    wr(4'h0, 8'hC0);
    check({7'h00, cpuHalt}, 8'h00);
    rd(4'h4);
    check(rdv & 8'h14, 8'h10);
    drive(1'b0, 1'b0, 8'h00);
    idle(3);
    rd(4'h4);
    check(rdv & 8'h01, 8'h00);
    wr(4'h0, 8'hC0);
    check({7'h00, cpuHalt}, 8'h01);
    idle(8);
    rd(4'h4);
    check(rdv & 8'h1C, 8'h04);
    drive(1'b1, 1'b0, 8'h05);
    waitRes();
    check({7'h00, timingClear}, 8'h01);
    drive(1'b0, 1'b0, 8'h00);
    $display("level release done");
  endtask : t_level
  task t_key;
    int i;
    int j;
    logic lvl;
    for (i = 0; i < 2; i++)
    begin
      lvl = i[0];
      drive(1'b0, !lvl, 8'h00);
      idle(3);
      wr(4'h3, {6'h00, 1'b1, lvl});
      wr(4'h0, 8'h80);
      idle(8);
      drive(1'b0, lvl, 8'h00);
      for (j = 0; j < 20 && warmupActive !== 1'b1; j++)
        idle(1);
      // a key release that never starts warm-up would otherwise go unnoticed
      if (warmupActive !== 1'b1)
      begin
        mismatches++;
        finish_test();
      end
      // reverse the key while warming up; the block must still resume
      drive(1'b0, !lvl, 8'h00);
      waitRes();
      check({7'h00, timingClear}, 8'h01);
      idle(10);
      rd(4'h4);
      check({cpuHalt, rdv[3:2]}, 8'h00);
    end
    wr(4'h3, 8'h00);
    $display("key release done");
  endtask : t_key
  task t_port;
    int n;
    n = 0;
    drive(1'b1, 1'b0, 8'h00);
    repeat (10)
    begin
      idle(1);
      if (extInterruptFive === 1'b1)
        n++;
    end
    check(8'(n), 8'h01);
    check({7'h00, sharedPortBit}, 8'h01);
    $display("port share done");
  endtask : t_port
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_edge();
    t_ignore();
    t_level();
    t_key();
    t_port();
    finish_test();
  end
endmodule : tb_smwr_stop_release
